//--- ipfs_pkg.sv
// shared constants, field layouts and state codes of the input protection fault sequencer
package ipfs_pkg;

	// core clock rate, used to turn times into cycle counts
	localparam int unsigned CLK_MHZ          = 25;

	// over-voltage response bound: latest switch opening after the trip, in ns
	localparam int unsigned OV_RESPONSE_NS   = 1000;
	// longest time, so the count rounds down
	localparam int unsigned OV_RESPONSE_CYC  = (OV_RESPONSE_NS * CLK_MHZ) / 1000;
	// input must sit below trip minus hysteresis this long before release, in us
	localparam int unsigned OV_RELEASE_US    = 8000;
	localparam int unsigned OV_RELEASE_CYC   = OV_RELEASE_US * CLK_MHZ;
	// persistence demanded of over-current and battery over-voltage, in us
	localparam int unsigned FAULT_DELAY_US   = 180;
	localparam int unsigned FAULT_DELAY_CYC  = FAULT_DELAY_US * CLK_MHZ;
	// off time after an over-current trip, in us
	localparam int unsigned OC_RECOVERY_US   = 64000;
	localparam int unsigned OC_RECOVERY_CYC  = OC_RECOVERY_US * CLK_MHZ;

	// width of every delay timer, wide enough for the recovery count
	localparam int          CNT_W            = 22;
	// consecutive trip counters and the trip count that locks the switch off
	localparam int          TRIP_W           = 5;
	localparam logic [4:0]  TRIP_LIMIT       = 5'h10;

	// indices of the comparator flags that pass through the qualifiers
	localparam int          FL_OV_TRIP       = 0;
	localparam int          FL_OV_REL        = 1;
	localparam int          FL_OC            = 2;
	localparam int          FL_BAT           = 3;
	localparam int          FL_HOT           = 4;
	localparam int          FL_COOL          = 5;
	localparam int          NFLAG            = 6;

	// register offsets on the plain register port
	localparam int          ADDR_W           = 4;
	localparam logic [3:0]  ADDR_STATUS      = 4'h0;
	localparam logic [3:0]  ADDR_MASK        = 4'h4;
	localparam logic [3:0]  ADDR_STATE       = 4'h8;

	// event bits, shared by status and mask
	localparam int          EV_OV            = 0;
	localparam int          EV_OC            = 1;
	localparam int          EV_BAT           = 2;
	localparam int          EV_OT            = 3;
	localparam int          EV_LOCK          = 4;
	localparam int          EV_W             = 5;
	localparam logic [4:0]  MASK_RESET       = 5'h00;

	// fields of the live state register
	localparam int          ST_PASS          = 0;
	localparam int          ST_OV            = 1;
	localparam int          ST_OC            = 2;
	localparam int          ST_BAT           = 3;
	localparam int          ST_OT            = 4;
	localparam int          ST_LOCK          = 5;
	localparam int          ST_OCCNT_LSB     = 8;
	localparam int          ST_BATCNT_LSB    = 16;

	// over-current handling states, one-hot
	typedef enum logic [2:0] {
		OC_RUN     = 3'h1,
		OC_RECOVER = 3'h2,
		OC_LOCKED  = 3'h4
	} ipfs_oc_e;

endpackage

//--- ipfs_qualify.sv
// two-flop synchroniser with a persistence counter for one comparator flag
`timescale 1ns/1ps
module ipfs_qualify #(
	parameter int unsigned HOLD = 1,   // cycles the flag must stay high
	parameter int          CW   = 22   // counter width, must hold HOLD
) (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic raw,        // asynchronous comparator output
	output logic      level,      // synchronised level
	output logic      qualified   // high once level held HOLD cycles
);

	localparam logic [CW-1:0] HOLD_C = CW'(HOLD);

	// whole state of the qualifier
	typedef struct packed {
		logic          sync1;   // first stage, read only by sync2
		logic          sync2;   // second stage, safe to use
		logic [CW-1:0] cnt;     // consecutive high cycles, saturating
		logic          qual;    // persistence reached
	} ipfs_qual_s;

	ipfs_qual_s st_reg;
	ipfs_qual_s st_next;

	// any low sample restarts the count, so short excursions never qualify
	always_comb begin
		st_next       = st_reg;
		st_next.sync1 = raw;
		st_next.sync2 = st_reg.sync1;
		if (!st_reg.sync2) begin
			st_next.cnt = '0;
		end else if (st_reg.cnt != HOLD_C) begin
			st_next.cnt = st_reg.cnt + CW'(1);
		end
		st_next.qual = (st_next.cnt == HOLD_C);
	end

	// state register, cleared by power-on reset
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level     = st_reg.sync2;
	assign qualified = st_reg.qual;

endmodule

//--- ipfs_fault_sequencer.sv
// fault sequencer of the input protection switch, with its register port and interrupt
//
// Overview of operation
// - open switch within 1us of over-voltage
// - reclose after 8ms below hysteresis, no faults
// - over-current acts only after 180us persistence
// - over-current trip waits 64ms before reclosing
// - sixteenth consecutive over-current trip locks switch off
// - battery over-voltage counts after 180us persistence
// - sixteen consecutive battery trips lock switch off
// - die over-temperature opens the switch
// - thermal recovery only after 20C cooling
// - warning low on faults except over-temperature
// - over-voltage level chosen at build time
`timescale 1ns/1ps
module ipfs_fault_sequencer #(
	parameter int unsigned OV_RELEASE_CYC  = ipfs_pkg::OV_RELEASE_CYC,
	parameter int unsigned FAULT_DELAY_CYC = ipfs_pkg::FAULT_DELAY_CYC,
	parameter int unsigned OC_RECOVERY_CYC = ipfs_pkg::OC_RECOVERY_CYC,
	parameter logic [1:0]  OV_LEVEL_SEL    = 2'h0   // one of four trip levels
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        over_voltage_guard,    // input above trip level
	input  wire logic        ov_release_in,         // input below trip minus 100mV
	input  wire logic        over_current_guard,    // current above limit set by resistor
	input  wire logic        battery_sense_input,   // battery above 4.35V
	input  wire logic        temp_hot_in,           // die at 140C
	input  wire logic        temp_cool_in,          // die 20C below trip
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	output logic             pass_switch_on,
	output logic             fault_warning_n,
	output logic      [1:0]  ov_level_sel          // trip level to the comparator
);

	localparam int           TW        = ipfs_pkg::CNT_W;
	localparam int           CW        = ipfs_pkg::TRIP_W;
	localparam logic [TW-1:0] OC_REC_LAST = TW'(OC_RECOVERY_CYC - 1);
	// longest response of the over-voltage path, for the check below
	localparam int           OV_MAX    = ipfs_pkg::OV_RESPONSE_CYC;

	// hold time for each qualified flag
	function automatic int unsigned hold_of(input int idx);
		case (idx)
			ipfs_pkg::FL_OV_REL: hold_of = OV_RELEASE_CYC;
			ipfs_pkg::FL_OC:     hold_of = FAULT_DELAY_CYC;
			ipfs_pkg::FL_BAT:    hold_of = FAULT_DELAY_CYC;
			default:             hold_of = 1;
		endcase
	endfunction

	// whole state of the sequencer
	typedef struct packed {
		logic                  ov_off;    // over-voltage shutdown active
		ipfs_pkg::ipfs_oc_e    oc_st;     // over-current handling
		logic [TW-1:0]         oc_tmr;    // recovery timer
		logic [CW-1:0]         oc_cnt;    // consecutive over-current trips
		logic                  bat_off;   // battery over-voltage shutdown
		logic [CW-1:0]         bat_cnt;   // consecutive battery trips
		logic                  bat_lock;  // battery lockout until reset
		logic                  ot_off;    // thermal shutdown
		logic [TW-1:0]         calm_tmr;  // time the switch has been closed
		logic                  pass_on;   // pass switch drive
		logic                  warn_n;    // warning output
		logic [ipfs_pkg::EV_W-1:0] status; // sticky events
		logic [ipfs_pkg::EV_W-1:0] mask;   // interrupt enables
		logic [31:0]           rdata;     // read answer
		logic                  irq;       // interrupt level
	} ipfs_seq_s;

	localparam ipfs_seq_s ST_RESET = '{
		ov_off:   1'h0,
		oc_st:    ipfs_pkg::OC_RUN,
		oc_tmr:   '0,
		oc_cnt:   '0,
		bat_off:  1'h0,
		bat_cnt:  '0,
		bat_lock: 1'h0,
		ot_off:   1'h0,
		calm_tmr: '0,
		pass_on:  1'h0,
		warn_n:   1'h1,
		status:   '0,
		mask:     ipfs_pkg::MASK_RESET,
		rdata:    '0,
		irq:      1'h0
	};

	ipfs_seq_s                   st_reg;     // registered state
	ipfs_seq_s                   st_next;    // next state
	logic [ipfs_pkg::NFLAG-1:0]  flag_raw;   // comparator flags from pins
	logic [ipfs_pkg::NFLAG-1:0]  flag_lvl;   // synchronised levels
	logic [ipfs_pkg::NFLAG-1:0]  flag_qual;  // persistence-qualified levels
	logic [ipfs_pkg::EV_W-1:0]   events;     // one-cycle event pulses
	logic [31:0]                 rd_val;     // addressed register contents
	logic                        lock_now;   // current lockout
	logic                        lock_nxt;   // next lockout

	assign flag_raw[ipfs_pkg::FL_OV_TRIP] = over_voltage_guard;
	assign flag_raw[ipfs_pkg::FL_OV_REL]  = ov_release_in;
	assign flag_raw[ipfs_pkg::FL_OC]      = over_current_guard;
	assign flag_raw[ipfs_pkg::FL_BAT]     = battery_sense_input;
	assign flag_raw[ipfs_pkg::FL_HOT]     = temp_hot_in;
	assign flag_raw[ipfs_pkg::FL_COOL]    = temp_cool_in;

	// every comparator flag is asynchronous to core_clk; one qualifier each
	for (genvar g = 0; g < ipfs_pkg::NFLAG; g++) begin : g_qual
		ipfs_qualify #(
			.HOLD (hold_of(g)),
			.CW   (TW)
		) u_qual (
			.core_clk  (core_clk),
			.reset     (reset),
			.raw       (flag_raw[g]),
			.level     (flag_lvl[g]),
			.qualified (flag_qual[g])
		);
	end

	// trip level is a strap of the product variant, not a register
	assign ov_level_sel = OV_LEVEL_SEL;

	// sequencing, events and register port in one pass
	always_comb begin
		st_next = st_reg;
		rd_val  = '0;

		// over-voltage: no persistence on the trip so the response stays short
		if (flag_lvl[ipfs_pkg::FL_OV_TRIP]) begin
			st_next.ov_off = 1'h1;
		end else if (st_reg.ov_off && flag_qual[ipfs_pkg::FL_OV_REL]) begin
			st_next.ov_off = 1'h0;
		end

		// a full recovery period with the switch closed ends a trip run
		if (st_reg.pass_on) begin
			if (st_reg.calm_tmr != OC_REC_LAST) begin
				st_next.calm_tmr = st_reg.calm_tmr + TW'(1);
			end else begin
				st_next.oc_cnt  = '0;
				st_next.bat_cnt = '0;
			end
		end else begin
			st_next.calm_tmr = '0;
		end

		// over-current sequence
		case (st_reg.oc_st)
			ipfs_pkg::OC_RUN: begin
				// only a flag held for the full delay reaches here
				if (flag_qual[ipfs_pkg::FL_OC]) begin
					st_next.oc_cnt = st_reg.oc_cnt + CW'(1);
					st_next.oc_tmr = '0;
					if (st_reg.oc_cnt + CW'(1) == ipfs_pkg::TRIP_LIMIT) begin
						st_next.oc_st = ipfs_pkg::OC_LOCKED;
					end else begin
						st_next.oc_st = ipfs_pkg::OC_RECOVER;
					end
				end
			end
			ipfs_pkg::OC_RECOVER: begin
				// fixed off time, regardless of the flag meanwhile
				if (st_reg.oc_tmr == OC_REC_LAST) begin
					st_next.oc_st  = ipfs_pkg::OC_RUN;
					st_next.oc_tmr = '0;
				end else begin
					st_next.oc_tmr = st_reg.oc_tmr + TW'(1);
				end
			end
			ipfs_pkg::OC_LOCKED: begin
				// only power-on reset leaves this state
				st_next.oc_st = ipfs_pkg::OC_LOCKED;
			end
			default: begin
				// an illegal code fails safe: switch off for good
				st_next.oc_st = ipfs_pkg::OC_LOCKED;
			end
		endcase

		// battery over-voltage; lockout freezes the counter
		if (!st_reg.bat_lock) begin
			if (!st_reg.bat_off && flag_qual[ipfs_pkg::FL_BAT]) begin
				st_next.bat_off = 1'h1;
				st_next.bat_cnt = st_reg.bat_cnt + CW'(1);
				if (st_reg.bat_cnt + CW'(1) == ipfs_pkg::TRIP_LIMIT) begin
					st_next.bat_lock = 1'h1;
				end
			end else if (st_reg.bat_off && !flag_lvl[ipfs_pkg::FL_BAT]) begin
				st_next.bat_off = 1'h0;
			end
		end

		// thermal shutdown with hysteresis between the two comparators
		if (flag_lvl[ipfs_pkg::FL_HOT]) begin
			st_next.ot_off = 1'h1;
		end else if (flag_lvl[ipfs_pkg::FL_COOL]) begin
			st_next.ot_off = 1'h0;
		end

		// switch closes only when every fault is gone
		st_next.pass_on = !(st_next.ov_off || st_next.oc_st != ipfs_pkg::OC_RUN ||
			st_next.bat_off || st_next.bat_lock || st_next.ot_off);

		// warning ignores thermal shutdown on purpose
		st_next.warn_n = !(st_next.ov_off || st_next.oc_st != ipfs_pkg::OC_RUN ||
			st_next.bat_off || st_next.bat_lock);

		// event pulses on entry into each shutdown
		lock_now = (st_reg.oc_st == ipfs_pkg::OC_LOCKED) || st_reg.bat_lock;
		lock_nxt = (st_next.oc_st == ipfs_pkg::OC_LOCKED) || st_next.bat_lock;
		events                    = '0;
		events[ipfs_pkg::EV_OV]   = st_next.ov_off && !st_reg.ov_off;
		events[ipfs_pkg::EV_OC]   = (st_reg.oc_st == ipfs_pkg::OC_RUN) &&
			(st_next.oc_st != ipfs_pkg::OC_RUN);
		events[ipfs_pkg::EV_BAT]  = st_next.bat_off && !st_reg.bat_off;
		events[ipfs_pkg::EV_OT]   = st_next.ot_off && !st_reg.ot_off;
		events[ipfs_pkg::EV_LOCK] = lock_nxt && !lock_now;

		// read mux
		case (reg_addr)
			ipfs_pkg::ADDR_STATUS: begin
				rd_val[ipfs_pkg::EV_W-1:0] = st_reg.status;
			end
			ipfs_pkg::ADDR_MASK: begin
				rd_val[ipfs_pkg::EV_W-1:0] = st_reg.mask;
			end
			ipfs_pkg::ADDR_STATE: begin
				rd_val[ipfs_pkg::ST_PASS] = st_reg.pass_on;
				rd_val[ipfs_pkg::ST_OV]   = st_reg.ov_off;
				rd_val[ipfs_pkg::ST_OC]   = st_reg.oc_st != ipfs_pkg::OC_RUN;
				rd_val[ipfs_pkg::ST_BAT]  = st_reg.bat_off;
				rd_val[ipfs_pkg::ST_OT]   = st_reg.ot_off;
				rd_val[ipfs_pkg::ST_LOCK] = lock_now;
				rd_val[ipfs_pkg::ST_OCCNT_LSB +: CW]  = st_reg.oc_cnt;
				rd_val[ipfs_pkg::ST_BATCNT_LSB +: CW] = st_reg.bat_cnt;
			end
			default: begin
				// unmapped offsets read as zero
				rd_val = '0;
			end
		endcase
		st_next.rdata = reg_rd ? rd_val : '0;

		// read clears status, but an event in the same cycle survives
		if (reg_rd && reg_addr == ipfs_pkg::ADDR_STATUS) begin
			st_next.status = events;
		end else begin
			st_next.status = st_reg.status | events;
		end
		if (reg_wr && reg_addr == ipfs_pkg::ADDR_MASK) begin
			st_next.mask = reg_wdata[ipfs_pkg::EV_W-1:0];
		end
		st_next.irq = |(st_next.status & st_next.mask);
	end

	// power-on reset clears counters and lockouts
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata       = st_reg.rdata;
	assign irq             = st_reg.irq;
	assign pass_switch_on  = st_reg.pass_on;
	assign fault_warning_n = st_reg.warn_n;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// an over-voltage trip at the pin opens the switch in time
	property p_ov_open;
		$rose(over_voltage_guard) |-> ##[1:OV_MAX] !pass_switch_on;
	endproperty
	a_ov_open: assert property (p_ov_open) else $error("switch not opened on over-voltage");

	// release of over-voltage needs the qualified hysteresis flag
	property p_ov_release;
		$fell(st_reg.ov_off) |-> $past(flag_qual[ipfs_pkg::FL_OV_REL]);
	endproperty
	a_ov_release: assert property (p_ov_release) else $error("early over-voltage release");

	// an unqualified over-current never trips
	property p_oc_ignore;
		(st_reg.oc_st == ipfs_pkg::OC_RUN) && !flag_qual[ipfs_pkg::FL_OC] |=>
			st_reg.oc_st != ipfs_pkg::OC_RECOVER;
	endproperty
	a_oc_ignore: assert property (p_oc_ignore) else $error("over-current trip too early");

	// the recovery leg ends only after the full timer
	sequence s_oc_leave;
		(st_reg.oc_st == ipfs_pkg::OC_RECOVER) ##1 (st_reg.oc_st == ipfs_pkg::OC_RUN);
	endsequence
	property p_oc_recovery;
		s_oc_leave |-> ($past(st_reg.oc_tmr) == OC_REC_LAST);
	endproperty
	a_oc_recovery: assert property (p_oc_recovery) else $error("recovery delay cut short");

	// sixteen trips lock, and the lock holds
	property p_oc_lock;
		(st_reg.oc_cnt == ipfs_pkg::TRIP_LIMIT) |-> (st_reg.oc_st == ipfs_pkg::OC_LOCKED)
			##1 (st_reg.oc_st == ipfs_pkg::OC_LOCKED) && !pass_switch_on;
	endproperty
	a_oc_lock: assert property (p_oc_lock) else $error("over-current lock missing");

	// battery shutdown only after the qualified flag
	property p_bat_qual;
		$rose(st_reg.bat_off) |-> $past(flag_qual[ipfs_pkg::FL_BAT]);
	endproperty
	a_bat_qual: assert property (p_bat_qual) else $error("battery trip not qualified");

	// sixteenth battery trip holds the switch off
	property p_bat_lock;
		(st_reg.bat_cnt == ipfs_pkg::TRIP_LIMIT) |-> st_reg.bat_lock ##1
			(st_reg.bat_lock && !pass_switch_on)[*2];
	endproperty
	a_bat_lock: assert property (p_bat_lock) else $error("battery lock missing");

	// a hot die opens the switch on the next cycle
	property p_ot_open;
		flag_lvl[ipfs_pkg::FL_HOT] |=> st_reg.ot_off && !pass_switch_on;
	endproperty
	a_ot_open: assert property (p_ot_open) else $error("thermal shutdown missing");

	// thermal recovery needs the cool comparator
	property p_ot_resume;
		$fell(st_reg.ot_off) |-> $past(flag_lvl[ipfs_pkg::FL_COOL]);
	endproperty
	a_ot_resume: assert property (p_ot_resume) else $error("thermal release without cooling");

	// thermal shutdown alone keeps the warning high
	property p_warn_ot;
		st_reg.ot_off && !st_reg.ov_off && !st_reg.bat_off && !st_reg.bat_lock &&
			(st_reg.oc_st == ipfs_pkg::OC_RUN) |-> fault_warning_n;
	endproperty
	a_warn_ot: assert property (p_warn_ot) else $error("warning set by thermal shutdown");

	// any other shutdown drives the warning low
	property p_warn_fault;
		st_reg.ov_off || st_reg.bat_off || (st_reg.oc_st != ipfs_pkg::OC_RUN) |->
			!fault_warning_n;
	endproperty
	a_warn_fault: assert property (p_warn_fault) else $error("warning missing");

endmodule

//--- ipfs_supply_model.sv
// behavioural input supply, load, battery and die model that yields the comparator flags
`timescale 1ns/1ps
module ipfs_supply_model #(
	parameter int LIMIT_MA = 1000,   // over-current limit set by the external resistor
	parameter int TRIP0_MV = 6000,   // four build-time trip levels, plain defaults
	parameter int TRIP1_MV = 6500,
	parameter int TRIP2_MV = 7000,
	parameter int TRIP3_MV = 7500
) (
	input  wire logic [1:0] ov_level_sel,
	input  int              vin_mv,
	input  int              load_ma,
	input  int              bat_mv,
	input  int              die_c,
	output logic            over_voltage_guard,
	output logic            ov_release_in,
	output logic            over_current_guard,
	output logic            battery_sense_input,
	output logic            temp_hot_in,
	output logic            temp_cool_in
);
	int trip_mv;   // level picked by the variant select, never changed at run time

	// variant select chooses one of four fixed levels
	always_comb begin
		case (ov_level_sel)
			2'h0: trip_mv = TRIP0_MV;
			2'h1: trip_mv = TRIP1_MV;
			2'h2: trip_mv = TRIP2_MV;
			default: trip_mv = TRIP3_MV;
		endcase
	end

	// analog comparators; hysteresis bands kept apart so flags never chatter together
	assign over_voltage_guard  = vin_mv > trip_mv;
	assign ov_release_in       = vin_mv < trip_mv - 100;
	assign over_current_guard  = load_ma > LIMIT_MA;
	assign battery_sense_input = bat_mv > 4350;
	assign temp_hot_in         = die_c >= 140;
	assign temp_cool_in        = die_c <= 120;
endmodule

//--- tb.sv
// self-checking bench of the fault sequencer against the supply model
`timescale 1ns/1ps
module tb;
	localparam int REL  = 20;   // shortened release count
	localparam int FDLY = 10;   // shortened persistence count
	localparam int REC  = 30;   // shortened recovery count

	logic        core_clk  = 1'b0;
	logic        reset     = 1'b1;
	logic [3:0]  reg_addr  = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	logic        irq;
	logic        pass_switch_on;
	logic        fault_warning_n;
	logic [1:0]  ov_level_sel;
	logic        ovg, ovr, ocg, bsi, hot, cool;   // comparator flags
	int          vin_mv  = 5000;                 // analog conditions set by the bench
	int          load_ma = 100;
	int          bat_mv  = 4000;
	int          die_c   = 40;
	int          failures = 0;
	int          checks   = 0;
	logic [31:0] rd;

	// free-running core clock
	always #20 core_clk = ~core_clk;

	ipfs_fault_sequencer #(.OV_RELEASE_CYC(REL), .FAULT_DELAY_CYC(FDLY),
		.OC_RECOVERY_CYC(REC), .OV_LEVEL_SEL(2'h2)) ipfs_fault_sequencer_inst (
		.core_clk(core_clk), .reset(reset), .over_voltage_guard(ovg), .ov_release_in(ovr),
		.over_current_guard(ocg), .battery_sense_input(bsi), .temp_hot_in(hot),
		.temp_cool_in(cool), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .pass_switch_on(pass_switch_on),
		.fault_warning_n(fault_warning_n), .ov_level_sel(ov_level_sel));

	ipfs_supply_model ipfs_supply_model_inst (
		.ov_level_sel(ov_level_sel), .vin_mv(vin_mv), .load_ma(load_ma), .bat_mv(bat_mv),
		.die_c(die_c), .over_voltage_guard(ovg), .ov_release_in(ovr),
		.over_current_guard(ocg), .battery_sense_input(bsi), .temp_hot_in(hot),
		.temp_cool_in(cool));

	// expected status word for a single event
	function automatic logic [31:0] ev_bit(input int b);
		return 32'h1 << b;
	endfunction

	// verdict and end of run, the only exit
	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one comparison; unknowns never match
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one-cycle write strobe
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle only
	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	// bounded wait for the switch to reach a level; a hang ends the run
	task automatic wait_pass(input logic exp, input int bound);
		int n;
		n = 0;
		while (pass_switch_on !== exp && n < bound) begin
			@(negedge core_clk);
			n++;
		end
		check("pass switch wait", pass_switch_on, exp);
		if (pass_switch_on !== exp)
			complete_run();
	endtask

	// power-on reset held for two cycles
	task automatic do_reset();
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		// the switch closes only at the first edge after release
		repeat (2) @(negedge core_clk);
	endtask

	// sixteen consecutive trips of one kind; only the last must stick
	task automatic trip_loop(input bit bat);
		for (int i = 0; i < 16; i++) begin
			@(posedge core_clk);
			if (bat)
				bat_mv <= 4500;
			else
				load_ma <= 2000;
			wait_pass(1'b0, FDLY + 8);
			check("warning in trip", fault_warning_n, 1'b0);
			@(posedge core_clk);
			bat_mv  <= 4000;
			load_ma <= 100;
			if (i < 15)
				wait_pass(1'b1, REC + 10);
		end
		repeat (REC + 20) @(negedge core_clk);
		check("switch locked", pass_switch_on, 1'b0);
		reg_read(ipfs_pkg::ADDR_STATE, rd);
		check("lock flag", rd[ipfs_pkg::ST_LOCK], 1'b1);
		rd = rd >> (bat ? ipfs_pkg::ST_BATCNT_LSB : ipfs_pkg::ST_OCCNT_LSB);
		check("trip count", rd[4:0], 32'h10);
		reg_read(ipfs_pkg::ADDR_STATUS, rd);
		check("status lock", rd, ev_bit(ipfs_pkg::EV_LOCK) |
			ev_bit(bat ? ipfs_pkg::EV_BAT : ipfs_pkg::EV_OC));
		do_reset();
		check("switch after reset", pass_switch_on, 1'b1);
		$display("test lockout %0d done", bat);
	endtask

	// watchdog on the whole run
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		complete_run();
	end

	// main sequence
	initial begin
		int len;
		logic [4:0] m;
		void'($urandom(10));
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		// registered outputs leave their reset values one edge after release
		repeat (2) @(negedge core_clk);
		check("switch after reset", pass_switch_on, 1'b1);
		check("warning after reset", fault_warning_n, 1'b1);
		check("level select", {30'h0, ov_level_sel}, 32'h2);
		reg_read(ipfs_pkg::ADDR_MASK, rd);
		check("mask reset", rd, 32'h0);
		reg_read(4'hC, rd);
		check("unmapped read", rd, 32'h0);
		$display("test reset done");

		// over-voltage with its interrupt masked first
		m = 5'($urandom) & ~5'(ev_bit(ipfs_pkg::EV_OV));
		reg_write(ipfs_pkg::ADDR_MASK, {27'h0, m});
		@(posedge core_clk);
		vin_mv <= 9000;
		wait_pass(1'b0, ipfs_pkg::OV_RESPONSE_CYC);
		check("warning on overvoltage", fault_warning_n, 1'b0);
		check("masked irq", irq, 1'b0);
		reg_write(ipfs_pkg::ADDR_MASK, ev_bit(ipfs_pkg::EV_OV));
		@(negedge core_clk);
		check("unmasked irq", irq, 1'b1);
		reg_read(ipfs_pkg::ADDR_STATUS, rd);
		check("status overvoltage", rd, ev_bit(ipfs_pkg::EV_OV));
		// read data stand one cycle only, then return to zero
		@(negedge core_clk);
		check("read data cleared", reg_rdata, 32'h0);
		reg_read(ipfs_pkg::ADDR_STATUS, rd);
		check("status cleared", rd, 32'h0);
		check("irq cleared", irq, 1'b0);
		@(posedge core_clk);
		vin_mv <= 5000;
		repeat (REL - 3) @(negedge core_clk);
		check("release too early", pass_switch_on, 1'b0);
		wait_pass(1'b1, 15);
		$display("test overvoltage done");

		// short over-current and battery excursions of random length are ignored
		for (int i = 0; i < 6; i++) begin
			len = 1 + int'($urandom % (FDLY - 3));
			@(posedge core_clk);
			if (i % 2)
				bat_mv <= 4500;
			else
				load_ma <= 2000;
			repeat (len) @(posedge core_clk);
			bat_mv  <= 4000;
			load_ma <= 100;
			repeat (6) @(negedge core_clk);
			check("short pulse ignored", pass_switch_on, 1'b1);
		end
		$display("test short pulses done");

		// sustained over-current then recovery delay
		@(posedge core_clk);
		load_ma <= 2000;
		wait_pass(1'b0, FDLY + 8);
		@(posedge core_clk);
		load_ma <= 100;
		repeat (REC - 12) @(negedge core_clk);
		check("recovery too early", pass_switch_on, 1'b0);
		wait_pass(1'b1, 20);
		repeat (REC + 10) @(negedge core_clk);
		$display("test overcurrent done");

		trip_loop(1'b0);
		trip_loop(1'b1);

		// thermal trip with hysteresis and no warning
		@(posedge core_clk);
		die_c <= 150;
		wait_pass(1'b0, 10);
		repeat (3) @(negedge core_clk);
		check("warning on thermal", fault_warning_n, 1'b1);
		@(posedge core_clk);
		die_c <= 130;
		repeat (20) @(negedge core_clk);
		check("hysteresis hold", pass_switch_on, 1'b0);
		@(posedge core_clk);
		die_c <= 100;
		wait_pass(1'b1, 10);
		reg_read(ipfs_pkg::ADDR_STATUS, rd);
		check("status thermal", rd, ev_bit(ipfs_pkg::EV_OT));
		$display("test thermal done");
		complete_run();
	end
endmodule
